// ===== nbsp_pkg.sv
/*
 Package for the nine-bit asynchronous serial port: register offsets,
 control bit positions, reset values, timing constants and shared types.
 Assumes a 250 MHz APB clock and 32-bit APB data.
*/
package nbsp_pkg;
	// Register byte offsets
	localparam logic [11:0] NBSP_CTRL_OFS = 12'h000;
	localparam logic [11:0] NBSP_BUF_OFS = 12'h004;
	localparam logic [11:0] NBSP_BAUD_OFS = 12'h008;
	localparam logic [11:0] NBSP_MASK_OFS = 12'h00c;
	// Control register bit positions
	localparam int NBSP_RXDONE_BIT = 0;
	localparam int NBSP_TXDONE_BIT = 1;
	localparam int NBSP_RB8_BIT = 2;
	localparam int NBSP_TB8_BIT = 3;
	localparam int NBSP_REN_BIT = 4;
	localparam int NBSP_MCE_BIT = 5;
	// Reset values
	localparam logic [15:0] NBSP_BAUD_RST = 16'h0869;
	localparam logic [1:0] NBSP_MASK_RST = 2'h0;
	// Frame layout: start, 8 data, ninth, stop
	localparam logic [3:0] NBSP_FRAME_BITS = 4'hb;
	localparam logic [3:0] NBSP_NINTH_IDX = 4'h9;
	localparam logic [3:0] NBSP_STOP_IDX = 4'ha;
	localparam logic [3:0] NBSP_DATA_BITS = 4'h8;
	// Oversampling of each bit period for receive mid-bit sampling
	localparam logic [3:0] NBSP_OVS = 4'hf;
	localparam logic [3:0] NBSP_OVS_MID = 4'h7;

	// Control word seen by the shared core
	typedef struct packed {
		logic mce;
		logic ren;
		logic tb8;
	} nbsp_ctrl_type;

	typedef enum logic [1:0] {
		NBSP_RX_IDLE,
		NBSP_RX_START,
		NBSP_RX_BITS
	} nbsp_rxst_type;
endpackage

// ===== nbsp_tick.sv
/*
 Bit-rate tick generator for the serial port.
 Assumes one clock; the divisor comes from a software register.
*/
`timescale 1ns/1ns
module nbsp_tick import nbsp_pkg::*; (
	input wire logic pclk, // Clock
	input wire logic presetn, // Async reset, active low
	input wire logic [15:0] div, // Cycles per oversample tick minus one
	output logic tick // One-cycle oversample enable
);
	typedef struct packed {
		logic [15:0] cnt;
		logic tick;
	} nbsp_tk_type;
	nbsp_tk_type s_r, s_nxt;

	// Free-running down counter; a new divisor takes effect at reload
	always_comb begin
		s_nxt = s_r;
		s_nxt.tick = 1'b0;
		if (s_r.cnt == 16'h0000) begin
			s_nxt.cnt = div;
			s_nxt.tick = 1'b1;
		end else begin
			s_nxt.cnt = s_r.cnt - 16'h0001;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign tick = s_r.tick;
endmodule

// ===== nbsp_top.sv
/*
 Nine-bit asynchronous serial port with an APB register slave.
 Holds the transmit and receive engines, the control register, the
 receive buffer and the interrupt mask. Assumes an APB master on pclk,
 and an asynchronous receive line synchronised here.
*/
// What this block does
// - Frame is start, eight data bits LSB first, ninth bit, stop: eleven bits.
// - Sent ninth bit equals software ninth_tx_bit at control bit 3.
// - Received ninth bit goes to ninth_rx_bit, bit 2; stop bit unchecked.
// - Writing serial_buffer while idle starts a transmit frame by itself; a write during a frame is ignored.
// - tx_done_flag, bit 1, sets when stop bit starts, after ninth bit.
// - Receiver accepts frames only while rx_enable_bit, bit 4, is set.
// - Accept only if rx_done_flag clear and, with address check, ninth bit one.
// - Without address check the received ninth bit does not matter.
// - Accepted frame loads buffer and ninth_rx_bit and sets rx_done_flag in the same cycle.
// - Rejected frame leaves buffer, ninth_rx_bit and rx_done_flag unchanged.
// - Interrupt raised, when enabled, while either done flag is one.
`timescale 1ns/1ns
module nbsp_top import nbsp_pkg::*; (
	input wire logic pclk, // APB clock, 250 MHz
	input wire logic presetn, // Async reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB access phase
	input wire logic pwrite, // APB write
	input wire logic [11:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic rx_pin, // Receive line, asynchronous
	output logic tx_pin, // Transmit line
	output logic irq // Serial port interrupt, level
);
	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
		logic rx_s1;
		logic rx_s2;
		logic rx_prev;
		// Control and status
		logic mce;
		logic ren;
		logic tb8;
		logic rb8;
		logic tx_done;
		logic rx_done;
		logic [1:0] mask;
		logic [15:0] baud;
		logic [7:0] rx_buf;
		// Transmitter
		logic tx_busy;
		logic [10:0] tx_sh;
		logic [3:0] tx_idx;
		logic [3:0] tx_ovs;
		logic tx_line;
		// Receiver
		nbsp_rxst_type rx_st;
		logic [8:0] rx_sh;
		logic [3:0] rx_idx;
		logic [3:0] rx_ovs;
		logic irq;
	} nbsp_st_type;
	nbsp_st_type s_r, s_nxt;

	logic tick;
	logic setup_ph;
	logic acc_ph;
	logic wr_ctrl;
	logic wr_buf;
	logic wr_baud;
	logic wr_mask;
	logic set_tx_done;
	logic set_rx_done;
	logic rx_accept;
	logic rx_sample;

	// True for a mapped register offset
	function automatic logic nbsp_mapped(input logic [11:0] a);
		nbsp_mapped = (a == NBSP_CTRL_OFS) || (a == NBSP_BUF_OFS) ||
			(a == NBSP_BAUD_OFS) || (a == NBSP_MASK_OFS);
	endfunction

	// Read mux: control bits, receive buffer, divisor, mask
	function automatic logic [31:0] nbsp_rd(input nbsp_st_type s, input logic [11:0] a);
		logic [31:0] v;
		v = 32'h0000_0000;
		case (a)
			NBSP_CTRL_OFS: begin
				v[NBSP_RXDONE_BIT] = s.rx_done;
				v[NBSP_TXDONE_BIT] = s.tx_done;
				v[NBSP_RB8_BIT] = s.rb8;
				v[NBSP_TB8_BIT] = s.tb8;
				v[NBSP_REN_BIT] = s.ren;
				v[NBSP_MCE_BIT] = s.mce;
			end
			NBSP_BUF_OFS: v[7:0] = s.rx_buf;
			NBSP_BAUD_OFS: v[15:0] = s.baud;
			NBSP_MASK_OFS: v[1:0] = s.mask;
			default: v = 32'h0000_0000;
		endcase
		nbsp_rd = v;
	endfunction

	nbsp_tick u_tick (
		.pclk(pclk),
		.presetn(presetn),
		.div(s_r.baud),
		.tick(tick)
	);

	// APB decode: one wait state, so pready comes in the second access cycle
	assign setup_ph = psel && penable && !s_r.pready;
	assign acc_ph = psel && penable && s_r.pready;
	assign wr_ctrl = acc_ph && pwrite && (paddr == NBSP_CTRL_OFS);
	assign wr_buf = acc_ph && pwrite && (paddr == NBSP_BUF_OFS);
	assign wr_baud = acc_ph && pwrite && (paddr == NBSP_BAUD_OFS);
	assign wr_mask = acc_ph && pwrite && (paddr == NBSP_MASK_OFS);

	// Receive verdict at the stop-bit sample point
	assign rx_sample = tick && (s_r.rx_ovs == NBSP_OVS_MID);
	assign set_tx_done = s_r.tx_busy && tick && (s_r.tx_ovs == NBSP_OVS) &&
		(s_r.tx_idx == NBSP_NINTH_IDX);
	assign rx_accept = (s_r.rx_st == NBSP_RX_BITS) && rx_sample && (s_r.rx_idx == NBSP_STOP_IDX) &&
		!s_r.rx_done && (!s_r.mce || s_r.rx_sh[8]);
	assign set_rx_done = rx_accept;

	always_comb begin
		s_nxt = s_r;
		// Two-flop synchroniser, edge detect on the second stage only
		s_nxt.rx_s1 = rx_pin;
		s_nxt.rx_s2 = s_r.rx_s1;
		s_nxt.rx_prev = s_r.rx_s2;

		// Bus answer
		s_nxt.pready = setup_ph;
		s_nxt.pslverr = setup_ph && !nbsp_mapped(paddr);
		s_nxt.prdata = (setup_ph && !pwrite) ? nbsp_rd(s_r, paddr) : 32'h0000_0000;

		// Software writes to control; done flags only cleared by writing zero
		if (wr_ctrl) begin
			s_nxt.mce = pwdata[NBSP_MCE_BIT];
			s_nxt.ren = pwdata[NBSP_REN_BIT];
			s_nxt.tb8 = pwdata[NBSP_TB8_BIT];
			s_nxt.rb8 = pwdata[NBSP_RB8_BIT];
			s_nxt.tx_done = pwdata[NBSP_TXDONE_BIT] & s_r.tx_done;
			s_nxt.rx_done = pwdata[NBSP_RXDONE_BIT] & s_r.rx_done;
		end
		if (wr_baud)
			s_nxt.baud = pwdata[15:0];
		if (wr_mask)
			s_nxt.mask = pwdata[1:0];

		// Transmit: a buffer write loads the whole frame, idle line is high
		if (wr_buf && !s_r.tx_busy) begin
			s_nxt.tx_busy = 1'b1;
			s_nxt.tx_sh = {1'b1, s_r.tb8, pwdata[7:0], 1'b0};
			s_nxt.tx_idx = 4'h0;
			s_nxt.tx_ovs = 4'h0;
		end else if (s_r.tx_busy && tick) begin
			s_nxt.tx_ovs = s_r.tx_ovs + 4'h1;
			if (s_r.tx_ovs == NBSP_OVS) begin
				s_nxt.tx_sh = {1'b1, s_r.tx_sh[10:1]};
				s_nxt.tx_idx = s_r.tx_idx + 4'h1;
				if (s_r.tx_idx == NBSP_STOP_IDX)
					s_nxt.tx_busy = 1'b0;
			end
		end
		s_nxt.tx_line = s_nxt.tx_busy ? s_nxt.tx_sh[0] : 1'b1;

		// Receive engine
		case (s_r.rx_st)
			NBSP_RX_IDLE: begin
				if (s_r.ren && s_r.rx_prev && !s_r.rx_s2) begin
					s_nxt.rx_st = NBSP_RX_START;
					s_nxt.rx_ovs = 4'h0;
				end
			end
			NBSP_RX_START: begin
				if (tick) begin
					s_nxt.rx_ovs = s_r.rx_ovs + 4'h1;
					if (rx_sample) begin
						// A start bit gone high by mid-bit was a glitch
						if (s_r.rx_s2)
							s_nxt.rx_st = NBSP_RX_IDLE;
						else begin
							s_nxt.rx_st = NBSP_RX_BITS;
							s_nxt.rx_idx = 4'h1;
						end
					end
				end
			end
			NBSP_RX_BITS: begin
				if (tick) begin
					s_nxt.rx_ovs = s_r.rx_ovs + 4'h1;
					if (rx_sample) begin
						if (s_r.rx_idx == NBSP_STOP_IDX) begin
							// Stop level is not checked
							s_nxt.rx_st = NBSP_RX_IDLE;
						end else begin
							s_nxt.rx_sh = {s_r.rx_s2, s_r.rx_sh[8:1]};
							s_nxt.rx_idx = s_r.rx_idx + 4'h1;
						end
					end
				end
			end
			default: s_nxt.rx_st = NBSP_RX_IDLE;
		endcase
		// Clearing receive enable drops a frame in flight
		if (!s_r.ren)
			s_nxt.rx_st = NBSP_RX_IDLE;

		// Accepted frame loads data; rejected frames touch nothing
		if (rx_accept) begin
			s_nxt.rx_buf = s_r.rx_sh[7:0];
			s_nxt.rb8 = s_r.rx_sh[8];
		end
		// Set wins over a software clear in the same cycle
		if (set_tx_done)
			s_nxt.tx_done = 1'b1;
		if (set_rx_done)
			s_nxt.rx_done = 1'b1;

		// Mask bit 0 gates receive done, bit 1 transmit done
		s_nxt.irq = (s_nxt.rx_done && s_nxt.mask[0]) || (s_nxt.tx_done && s_nxt.mask[1]);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			s_r <= '0;
			s_r.rx_s1 <= 1'b1;
			s_r.rx_s2 <= 1'b1;
			s_r.rx_prev <= 1'b1;
			s_r.tx_line <= 1'b1;
			s_r.baud <= NBSP_BAUD_RST;
			s_r.mask <= NBSP_MASK_RST;
			s_r.tx_sh <= 11'h7ff;
			s_r.rx_st <= NBSP_RX_IDLE;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign prdata = s_r.prdata;
	assign pready = s_r.pready;
	assign pslverr = s_r.pslverr;
	assign tx_pin = s_r.tx_line;
	assign irq = s_r.irq;

	// Assertions
	a_tx_frame_start: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_buf && !s_r.tx_busy) |=> (s_r.tx_busy && tx_pin == 1'b0))
		else $error("buffer write did not start a frame");

	a_tx_ninth_bit: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_buf && !s_r.tx_busy) |=>
		(s_r.tx_sh[9] == $past(s_r.tb8) && s_r.tx_sh[8:1] == $past(pwdata[7:0])))
		else $error("ninth bit not loaded");

	a_tx_done_time: assert property (@(posedge pclk) disable iff (!presetn)
		set_tx_done |=> (s_r.tx_done && s_r.tx_idx == NBSP_STOP_IDX && tx_pin))
		else $error("tx done not at stop start");

	a_rx_off_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!s_r.ren |=> s_r.rx_st == NBSP_RX_IDLE)
		else $error("receiver active while disabled");

	sequence nbsp_stop_sample;
		(s_r.rx_st == NBSP_RX_BITS) && rx_sample && (s_r.rx_idx == NBSP_STOP_IDX);
	endsequence

	a_rx_accept_ok: assert property (@(posedge pclk) disable iff (!presetn)
		(nbsp_stop_sample and (!s_r.rx_done && (!s_r.mce || s_r.rx_sh[8]))) |=>
		(s_r.rx_done && s_r.rb8 == $past(s_r.rx_sh[8]) && s_r.rx_buf == $past(s_r.rx_sh[7:0])))
		else $error("accepted frame not stored");

	a_rx_reject_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(nbsp_stop_sample and (s_r.mce && !s_r.rx_sh[8] && !wr_ctrl)) |=>
		($stable(s_r.rx_buf) && $stable(s_r.rb8) && $stable(s_r.rx_done)))
		else $error("rejected frame changed state");

	a_rx_busy_keep: assert property (@(posedge pclk) disable iff (!presetn)
		(nbsp_stop_sample and (s_r.rx_done && !wr_ctrl)) |=> $stable(s_r.rx_buf))
		else $error("frame overwrote unread buffer");

	a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
		irq == ((s_r.rx_done && s_r.mask[0]) || (s_r.tx_done && s_r.mask[1])))
		else $error("interrupt missing");

	a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.tx_done && !wr_ctrl) |=> s_r.tx_done)
		else $error("tx done cleared by hardware");

	a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
		(psel && penable && !pready) |=> pready)
		else $error("apb answer late");

	// First access cycle of a transfer, before the wait state ends
	sequence nbsp_apb_first;
		psel && penable && !pready;
	endsequence

	a_slverr_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
		(nbsp_apb_first and (!nbsp_mapped(paddr))) |=> (pready && pslverr))
		else $error("unmapped access not flagged");

	a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
		pready |=> !pready)
		else $error("ready held too long");

	a_prdata_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!pready |-> prdata == 32'h0000_0000)
		else $error("read data outside answer");

	a_rx_done_sticky: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.rx_done && !wr_ctrl) |=> s_r.rx_done)
		else $error("rx done cleared by hardware");

	a_ninth_rx_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(!rx_accept && !wr_ctrl) |=> $stable(s_r.rb8))
		else $error("received ninth bit changed");

	a_rx_buf_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!rx_accept |=> $stable(s_r.rx_buf))
		else $error("receive buffer changed");

	a_rx_stop_free: assert property (@(posedge pclk) disable iff (!presetn)
		(nbsp_stop_sample and (!s_r.rx_done && !s_r.mce && !s_r.rx_s2)) |=> s_r.rx_done)
		else $error("low stop level blocked a frame");

	a_rx_start_edge: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.rx_st == NBSP_RX_IDLE && s_r.ren && s_r.rx_prev && !s_r.rx_s2) |=>
		s_r.rx_st == NBSP_RX_START)
		else $error("falling edge not taken as start");

	a_rx_mid_shift: assert property (@(posedge pclk) disable iff (!presetn)
		(s_r.rx_st == NBSP_RX_BITS && rx_sample && s_r.rx_idx != NBSP_STOP_IDX) |=>
		s_r.rx_sh[8] == $past(s_r.rx_s2))
		else $error("mid-bit sample not shifted in");

	a_tx_line_idle: assert property (@(posedge pclk) disable iff (!presetn)
		!s_r.tx_busy |-> tx_pin)
		else $error("transmit line not idle high");

	// A buffer write during a frame must not disturb the frame
	a_tx_busy_hold: assert property (@(posedge pclk) disable iff (!presetn)
		(wr_buf && s_r.tx_busy && !tick) |=> $stable(s_r.tx_sh))
		else $error("busy buffer write changed frame");
endmodule

// ===== nbsp_peer.sv
/*
 Far-side serial node for the nine-bit port: sends frames to the
 receive line and decodes frames seen on the transmit line.
 Assumes the same pclk as the port and a fixed bit period in cycles.
*/
`timescale 1ns/1ns
module nbsp_peer #(
	parameter int BIT = 32
) (
	input wire logic pclk, // Clock
	input wire logic tx_line, // Port transmit line
	output logic rx_line // Port receive line
);
	logic [8:0] got;
	int n_got;
	int n_done;

	initial begin
		rx_line = 1'b1;
		got = 9'h0;
		n_got = 0;
		n_done = 0;
	end

	// Start, data LSB first, ninth, stop; line rests high after
	task automatic send(input logic [7:0] d, input logic b9, input logic sb = 1'b1);
		logic [10:0] f;
		f = {sb, b9, d, 1'b0};
		for (int i = 0; i < 11; i++) begin
			rx_line <= f[i];
			repeat (BIT) @(posedge pclk);
		end
		// A low stop level is allowed; rest high afterwards
		rx_line <= 1'b1;
	endtask

	// Mid-bit decode; n_done moves only at stop-bit middle
	always begin
		@(negedge tx_line);
		repeat (BIT / 2) @(posedge pclk);
		for (int i = 0; i < 9; i++) begin
			repeat (BIT) @(posedge pclk);
			got[i] = tx_line;
		end
		n_got++;
		repeat (BIT) @(posedge pclk);
		n_done++;
	end
endmodule

// ===== nbsp_top_test.sv
/*
 Testbench for the nine-bit serial port: APB tasks, a serial peer,
 transmit and receive sequences with expected values.
 Assumes nbsp_top and nbsp_peer; divisor set to 1 for short frames.
*/
`timescale 1ns/1ns
module nbsp_top_test import nbsp_pkg::*;;
	localparam int BIT = 32;
	logic pclk, presetn, psel, penable, pwrite, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic pready, pslverr, rx_pin, tx_pin, irq;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;

	nbsp_top nbsp_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
	nbsp_peer #(.BIT(BIT)) nbsp_peer_i (.pclk(pclk), .tx_line(tx_pin), .rx_line(rx_pin));

	always #2 pclk = ~pclk;

	task automatic end_of_test();
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// Cut a hang short; frames need well under this
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_mismatch++;
			end_of_test();
		end
	end

	task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			$display("wrong value %s expected %h seen %h", n, exp, seen);
			n_mismatch++;
		end
	endtask

	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string n);
		apb(1'b0, a, 32'h0);
		chk(n, rd, exp);
	endtask

	initial begin
		logic [7:0] d;
		logic tb;
		{pclk, presetn, psel, penable, pwrite} = 5'h0;
		paddr = 12'h0;
		pwdata = 32'h0;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		rdc(NBSP_CTRL_OFS, 32'h0, "ctrl reset");
		rdc(NBSP_MASK_OFS, 32'h0, "mask reset");
		rdc(NBSP_BAUD_OFS, {16'h0, NBSP_BAUD_RST}, "baud reset");
		apb(1'b0, 12'h010, 32'h0);
		chk("slverr", {31'h0, er}, 32'h1);
		chk("unmapped", rd, 32'h0);
		apb(1'b1, NBSP_BAUD_OFS, 32'h1);
		// Old divisor must run out before the new one is reloaded
		repeat (int'(NBSP_BAUD_RST) + 2) @(posedge pclk);
		apb(1'b1, NBSP_MASK_OFS, 32'h3);
		// Transmit with ninth bit one then zero
		for (int k = 0; k < 2; k++) begin
			d = (k == 0) ? 8'ha5 : 8'h3c;
			tb = (k == 0);
			apb(1'b1, NBSP_CTRL_OFS, {28'h0, tb, 3'h0});
			apb(1'b1, NBSP_BUF_OFS, {24'h0, d});
			apb(1'b1, NBSP_BUF_OFS, 32'hff); // Ignored while the frame runs
			do apb(1'b0, NBSP_CTRL_OFS, 32'h0); while (rd[1] !== 1'b1);
			chk("stop not done", nbsp_peer_i.n_done, k);
			chk("frame", {23'h0, nbsp_peer_i.got}, {23'h0, tb, d});
			chk("irq tx", {31'h0, irq}, 32'h1);
			repeat (2 * BIT) @(posedge pclk);
			rdc(NBSP_CTRL_OFS, {28'h0, tb, 3'h2}, "tx flag held");
			apb(1'b1, NBSP_CTRL_OFS, {28'h0, tb, 3'h0});
			rdc(NBSP_CTRL_OFS, {28'h0, tb, 3'h0}, "tx flag clear");
			chk("irq off", {31'h0, irq}, 32'h0);
		end
		// Receive disabled, then plain, then blocked by full flag
		apb(1'b1, NBSP_CTRL_OFS, 32'h0);
		nbsp_peer_i.send(8'h77, 1'b1);
		rdc(NBSP_CTRL_OFS, 32'h0, "rx off");
		apb(1'b1, NBSP_CTRL_OFS, 32'h10);
		nbsp_peer_i.send(8'h5a, 1'b0);
		rdc(NBSP_CTRL_OFS, 32'h11, "rx accept");
		rdc(NBSP_BUF_OFS, 32'h5a, "rx byte");
		chk("irq rx", {31'h0, irq}, 32'h1);
		nbsp_peer_i.send(8'h11, 1'b1);
		rdc(NBSP_CTRL_OFS, 32'h11, "rx full");
		rdc(NBSP_BUF_OFS, 32'h5a, "rx kept");
		// Low stop level is not checked
		apb(1'b1, NBSP_CTRL_OFS, 32'h10);
		nbsp_peer_i.send(8'hc3, 1'b0, 1'b0);
		rdc(NBSP_CTRL_OFS, 32'h11, "stop free");
		rdc(NBSP_BUF_OFS, 32'hc3, "stop byte");
		// Address check: ninth zero dropped, ninth one taken
		apb(1'b1, NBSP_CTRL_OFS, 32'h30);
		nbsp_peer_i.send(8'h22, 1'b0);
		rdc(NBSP_CTRL_OFS, 32'h30, "mce drop");
		nbsp_peer_i.send(8'h96, 1'b1);
		rdc(NBSP_CTRL_OFS, 32'h35, "mce take");
		rdc(NBSP_BUF_OFS, 32'h96, "mce byte");
		apb(1'b1, NBSP_MASK_OFS, 32'h2);
		rdc(NBSP_MASK_OFS, 32'h2, "mask");
		chk("irq masked", {31'h0, irq}, 32'h0);
		end_of_test();
	end
endmodule
